// [hdl/sec_ctrl.sv]
// Serial EEPROM host controller: registers, frame sequencer and station address reload
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "sec_defs.svh"

module sec_ctrl #(
    parameter int unsigned TIMEOUT_CYC = `SEC_TIMEOUT_MS * `SEC_CLK_KHZ,
    parameter int unsigned SCLK_HALF = `SEC_SCLK_HALF
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // EEPROM pins
    output logic o_cs,
    output logic o_sclk,
    output logic o_sd,
    output logic o_sd_oe_n,
    input wire logic i_sd,
    // Station address to the MAC
    output logic [47:0] o_station_addr
);

    // Frame bits for a command, MSB aligned: start, opcode, address, data
    function automatic logic [17:0] sec_frame(input sec_pkg::sec_cmd_e c, input logic [6:0] a,
                                              input logic [7:0] d);
        unique case (c)
            sec_pkg::SEC_CMD_READ, sec_pkg::SEC_CMD_RELOAD: sec_frame = {3'b110, a, 8'h00};
            sec_pkg::SEC_CMD_WRITE: sec_frame = {3'b101, a, d};
            sec_pkg::SEC_CMD_ERASE: sec_frame = {3'b111, a, 8'h00};
            sec_pkg::SEC_CMD_UNLOCK: sec_frame = {3'b100, 7'h60, 8'h00};
            sec_pkg::SEC_CMD_LOCK: sec_frame = {3'b100, 7'h00, 8'h00};
            sec_pkg::SEC_CMD_CLEAR_ALL: sec_frame = {3'b100, 7'h40, 8'h00};
            sec_pkg::SEC_CMD_FILL_ALL: sec_frame = {3'b100, 7'h20, d};
        endcase
    endfunction

    // Serial clock count of a command
    function automatic logic [4:0] sec_len(input sec_pkg::sec_cmd_e c);
        unique case (c)
            sec_pkg::SEC_CMD_READ, sec_pkg::SEC_CMD_RELOAD, sec_pkg::SEC_CMD_WRITE,
            sec_pkg::SEC_CMD_FILL_ALL: sec_len = `SEC_LEN_LONG;
            default: sec_len = `SEC_LEN_SHORT;
        endcase
    endfunction

    // Commands that program the array and end with a ready wait
    function automatic logic sec_prog(input sec_pkg::sec_cmd_e c);
        sec_prog = (c == sec_pkg::SEC_CMD_WRITE) || (c == sec_pkg::SEC_CMD_FILL_ALL) ||
                   (c == sec_pkg::SEC_CMD_ERASE) || (c == sec_pkg::SEC_CMD_CLEAR_ALL);
    endfunction

    sec_pkg::sec_state_e st_q;
    sec_pkg::sec_cmd_e cmd_q;
    logic [6:0] tgt_q;
    logic pend_q, to_q, load_q, init_q, rld_q, kick_q, rxm_q;
    logic [7:0] data_q, rx_q;
    logic [47:0] sta_q;
    logic [2:0] idx_q, pincfg_q;
    logic [17:0] tx_q;
    logic [4:0] nb_q, bc_q;
    logic [7:0] half_q;
    logic [19:0] tmo_q;
    logic sclk_q, cs_q;
    logic sd_m_q, sd_s_q;
    logic cmd_wr, host_ok;

    assign host_ok = !pend_q && !init_q;
    assign cmd_wr = i_wr && (i_addr == `SEC_OFF_CMD) && host_ok;

    // Two-flop synchroniser for the serial data input
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sd_m_q <= 1'b0;
            sd_s_q <= 1'b0;
        end else begin
            sd_m_q <= i_sd;
            sd_s_q <= sd_m_q;
        end
    end

    // Pin configuration register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pincfg_q <= `SEC_PINCFG_RST;
        end else if (i_wr && i_addr == `SEC_OFF_PINCFG) begin
            pincfg_q <= i_wdata[2:0];
        end
    end

    // Command, data, station address and the frame sequencer
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q <= sec_pkg::SEC_ST_IDLE;
            cmd_q <= sec_pkg::SEC_CMD_READ;
            tgt_q <= 7'h00;
            pend_q <= 1'b0;
            to_q <= 1'b0;
            load_q <= 1'b0;
            init_q <= 1'b1;
            rld_q <= 1'b1;
            kick_q <= 1'b1;
            rxm_q <= 1'b0;
            idx_q <= 3'h0;
            data_q <= 8'h00;
            rx_q <= 8'h00;
            sta_q <= 48'h0;
            tx_q <= 18'h0;
            nb_q <= 5'h00;
            bc_q <= 5'h00;
            half_q <= 8'h00;
            tmo_q <= 20'h0;
            sclk_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            // Command, data and station address writes are taken only while nothing is in flight
            if (cmd_wr) begin
                cmd_q <= sec_pkg::sec_cmd_e'(i_wdata[`SEC_CMD_CODE_HI:`SEC_CMD_CODE_LO]);
                tgt_q <= i_wdata[`SEC_CMD_ADDR_HI:0];
                if (i_wdata[`SEC_CMD_PEND]) begin
                    pend_q <= 1'b1;
                    kick_q <= 1'b1;
                    to_q <= 1'b0;
                    if (i_wdata[`SEC_CMD_CODE_HI:`SEC_CMD_CODE_LO] == sec_pkg::SEC_CMD_RELOAD) begin
                        rld_q <= 1'b1;
                        idx_q <= 3'h0;
                        load_q <= 1'b0;
                    end
                end
            end
            if (i_wr && i_addr == `SEC_OFF_DATA && host_ok) begin
                data_q <= i_wdata[7:0];
            end
            if (i_wr && i_addr == `SEC_OFF_STA_LO && host_ok) begin
                sta_q[31:0] <= i_wdata;
            end
            if (i_wr && i_addr == `SEC_OFF_STA_HI && host_ok) begin
                sta_q[47:32] <= i_wdata[15:0];
            end
            unique case (st_q)
                sec_pkg::SEC_ST_IDLE: begin
                    if (kick_q) begin
                        kick_q <= 1'b0;
                        if (rld_q) begin
                            tx_q <= sec_frame(sec_pkg::SEC_CMD_READ, {4'h0, idx_q}, 8'h00);
                            nb_q <= `SEC_LEN_LONG;
                            bc_q <= `SEC_LEN_LONG;
                            rxm_q <= 1'b1;
                        end else begin
                            tx_q <= sec_frame(cmd_q, tgt_q, data_q);
                            nb_q <= sec_len(cmd_q);
                            bc_q <= sec_len(cmd_q);
                            rxm_q <= (cmd_q == sec_pkg::SEC_CMD_READ);
                        end
                        cs_q <= 1'b1;
                        sclk_q <= 1'b0;
                        half_q <= 8'h00;
                        st_q <= sec_pkg::SEC_ST_SHIFT;
                    end
                end
                sec_pkg::SEC_ST_SHIFT: begin
                    if (half_q == 8'(SCLK_HALF - 1)) begin
                        half_q <= 8'h00;
                        if (!sclk_q) begin
                            sclk_q <= 1'b1;
                        end else begin
                            // Falling edge: sample, then present the next bit MSB first
                            sclk_q <= 1'b0;
                            rx_q <= {rx_q[6:0], sd_s_q};
                            tx_q <= {tx_q[16:0], 1'b0};
                            if (bc_q == 5'h01) begin
                                cs_q <= 1'b0;
                                if (sec_prog(cmd_q) && !rld_q) begin
                                    st_q <= sec_pkg::SEC_ST_GAP;
                                end else begin
                                    st_q <= sec_pkg::SEC_ST_DONE;
                                end
                            end else begin
                                bc_q <= bc_q - 5'h01;
                            end
                        end
                    end else begin
                        half_q <= half_q + 8'h01;
                    end
                end
                sec_pkg::SEC_ST_GAP: begin
                    // Chip select low for one half period before polling ready
                    if (half_q == 8'(SCLK_HALF - 1)) begin
                        half_q <= 8'h00;
                        cs_q <= 1'b1;
                        tmo_q <= 20'h0;
                        st_q <= sec_pkg::SEC_ST_WAIT;
                    end else begin
                        half_q <= half_q + 8'h01;
                    end
                end
                sec_pkg::SEC_ST_WAIT: begin
                    if (sd_s_q && tmo_q >= 20'(SCLK_HALF)) begin
                        cs_q <= 1'b0;
                        st_q <= sec_pkg::SEC_ST_DONE;
                    end else if (tmo_q == 20'(TIMEOUT_CYC - 1)) begin
                        cs_q <= 1'b0;
                        to_q <= 1'b1;
                        st_q <= sec_pkg::SEC_ST_DONE;
                    end else begin
                        tmo_q <= tmo_q + 20'h1;
                    end
                end
                sec_pkg::SEC_ST_DONE: begin
                    st_q <= sec_pkg::SEC_ST_IDLE;
                    if (rld_q) begin
                        if (idx_q == 3'h0 && rx_q != `SEC_MARKER) begin
                            rld_q <= 1'b0;
                            pend_q <= 1'b0;
                            init_q <= 1'b0;
                        end else if (idx_q == 3'h0) begin
                            idx_q <= 3'h1;
                            kick_q <= 1'b1;
                        end else begin
                            sta_q[{idx_q - 3'h1, 3'h0} +: 8] <= rx_q;
                            if (idx_q == `SEC_ADDR_BYTES) begin
                                load_q <= 1'b1;
                                rld_q <= 1'b0;
                                pend_q <= 1'b0;
                                init_q <= 1'b0;
                            end else begin
                                idx_q <= idx_q + 3'h1;
                                kick_q <= 1'b1;
                            end
                        end
                    end else begin
                        if (cmd_q == sec_pkg::SEC_CMD_READ) begin
                            data_q <= rx_q;
                        end
                        pend_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Pin drivers; a disabled interface hands the clock and data pins to general outputs and holds chip select low
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_cs <= 1'b0;
            o_sclk <= 1'b0;
            o_sd <= 1'b0;
            o_sd_oe_n <= 1'b1;
        end else if (pincfg_q[`SEC_PIN_EN]) begin
            o_cs <= cs_q;
            o_sclk <= sclk_q;
            o_sd <= tx_q[17];
            o_sd_oe_n <= !(st_q == sec_pkg::SEC_ST_SHIFT && !(rxm_q && bc_q <= 5'h08));
        end else begin
            o_cs <= 1'b0;
            o_sclk <= pincfg_q[`SEC_PIN_GPO_CLK];
            o_sd <= pincfg_q[`SEC_PIN_GPO_DATA];
            o_sd_oe_n <= 1'b0;
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            unique case (i_addr)
                `SEC_OFF_CMD: o_rdata <= {pend_q | init_q, cmd_q, 18'h0, to_q, load_q, 1'b0, tgt_q};
                `SEC_OFF_DATA: o_rdata <= {24'h0, data_q};
                `SEC_OFF_PINCFG: o_rdata <= {29'h0, pincfg_q};
                `SEC_OFF_STA_LO: o_rdata <= sta_q[31:0];
                `SEC_OFF_STA_HI: o_rdata <= {16'h0, sta_q[47:32]};
                default: o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    // Station address output
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_station_addr <= 48'h0;
        end else begin
            o_station_addr <= sta_q;
        end
    end

    // Helper: serial clock rises counted within one chip select period
    logic [4:0] rise_cnt_q;
    logic sclk_prev_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rise_cnt_q <= 5'h00;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_q;
            if (!cs_q) begin
                rise_cnt_q <= 5'h00;
            end else if (sclk_q && !sclk_prev_q) begin
                rise_cnt_q <= rise_cnt_q + 5'h01;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_init_block;
        init_q && i_wr && i_addr == `SEC_OFF_CMD |=> cmd_q == $past(cmd_q);
    endproperty
    a_init_block: assert property (p_init_block) else $error("command taken during load");

    property p_pend_clear;
        st_q == sec_pkg::SEC_ST_DONE && !rld_q |=> !pend_q ##1 st_q == sec_pkg::SEC_ST_IDLE;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending bit not cleared");

    property p_read_data;
        st_q == sec_pkg::SEC_ST_DONE && !rld_q && cmd_q == sec_pkg::SEC_CMD_READ
            |=> data_q == $past(rx_q);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not stored");

    property p_timeout;
        st_q == sec_pkg::SEC_ST_WAIT && !sd_s_q && tmo_q == 20'(TIMEOUT_CYC - 1) |=> to_q && !cs_q;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not set");

    property p_release;
        !pincfg_q[`SEC_PIN_EN] |=> !o_cs && !o_sd_oe_n && o_sclk == $past(pincfg_q[1]);
    endproperty
    a_release: assert property (p_release) else $error("pins not released");

    property p_frame_len;
        $fell(cs_q) |-> rise_cnt_q == nb_q || rise_cnt_q == 5'h00;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("wrong serial clock count");

    property p_marker;
        st_q == sec_pkg::SEC_ST_DONE && rld_q && idx_q == 3'h0 && rx_q != `SEC_MARKER
            |=> !load_q && !pend_q && !rld_q;
    endproperty
    a_marker: assert property (p_marker) else $error("unmarked EEPROM accepted");

    property p_load_done;
        $rose(load_q) |-> $past(rld_q) && $past(idx_q) == `SEC_ADDR_BYTES;
    endproperty
    a_load_done: assert property (p_load_done) else $error("load flag without reload");

    property p_station;
        st_q == sec_pkg::SEC_ST_DONE && rld_q && idx_q == 3'h1 |=> sta_q[7:0] == $past(rx_q);
    endproperty
    a_station: assert property (p_station) else $error("first address byte misplaced");

    property p_start_bit;
        st_q == sec_pkg::SEC_ST_IDLE && kick_q |=> cs_q && tx_q[17] && !sclk_q;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("frame without start bit");

    c_read: cover property (st_q == sec_pkg::SEC_ST_DONE && cmd_q == sec_pkg::SEC_CMD_READ);
    c_timeout: cover property ($rose(to_q));
    c_loaded: cover property ($rose(load_q));

endmodule
`default_nettype wire

// [hdl/sec_defs.svh]
// Register map, field positions, reset values and timing figures of the EEPROM controller
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH

// Register byte offsets
`define SEC_OFF_CMD 8'h00
`define SEC_OFF_DATA 8'h04
`define SEC_OFF_PINCFG 8'h08
`define SEC_OFF_STA_LO 8'h0c
`define SEC_OFF_STA_HI 8'h10

// Command register fields
`define SEC_CMD_PEND 31
`define SEC_CMD_CODE_HI 30
`define SEC_CMD_CODE_LO 28
`define SEC_CMD_TO 9
`define SEC_CMD_LOAD 8
`define SEC_CMD_ADDR_HI 6

// Pin configuration fields and reset value
`define SEC_PIN_EN 0
`define SEC_PIN_GPO_CLK 1
`define SEC_PIN_GPO_DATA 2
`define SEC_PINCFG_RST 3'h1

// Frame figures
`define SEC_MARKER 8'ha5
`define SEC_LEN_SHORT 5'h0a
`define SEC_LEN_LONG 5'h12
`define SEC_ADDR_BYTES 3'h6

// Timing: system clock in kHz, timeout in ms, serial clock half period in cycles
`define SEC_CLK_KHZ 25000
`define SEC_TIMEOUT_MS 30
`define SEC_SCLK_HALF 8

`endif

// [hdl/sec_pkg.sv]
// Types shared by the serial EEPROM controller
package sec_pkg;

    // Command codes held in the command code field
    typedef enum logic [2:0] {
        SEC_CMD_READ = 3'h0,
        SEC_CMD_LOCK = 3'h1,
        SEC_CMD_UNLOCK = 3'h2,
        SEC_CMD_WRITE = 3'h3,
        SEC_CMD_FILL_ALL = 3'h4,
        SEC_CMD_ERASE = 3'h5,
        SEC_CMD_CLEAR_ALL = 3'h6,
        SEC_CMD_RELOAD = 3'h7
    } sec_cmd_e;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        SEC_ST_IDLE = 5'b00001,
        SEC_ST_SHIFT = 5'b00010,
        SEC_ST_GAP = 5'b00100,
        SEC_ST_WAIT = 5'b01000,
        SEC_ST_DONE = 5'b10000
    } sec_state_e;

endpackage

// [sim/sec_eeprom_model.sv]
// Behavioural 128 x 8 three-wire serial EEPROM facing the controller pins
`timescale 1ns/100ps
`default_nettype none
module sec_eeprom_model (
    // Clock used to find pin edges and to count down the busy time
    input wire logic i_clk,
    // Serial pins
    input wire logic i_cs,
    input wire logic i_sclk,
    input wire logic i_di,
    output logic o_drive,
    output logic o_do
);
    logic [7:0] mem [0:127];
    logic [17:0] sr;
    logic [4:0] rises;
    logic [4:0] falls;
    logic sclk_q;
    logic cs_q;
    logic unlocked;
    logic pend;
    logic [5:0] busy;
    logic [1:0] op;
    logic [6:0] adr;

    // Power-up contents: marker, six station bytes, rest blank; powers up locked
    initial begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'hff;
        mem[0] = 8'ha5;
        for (int i = 1; i < 7; i++)
            mem[i] = 8'(i * 17);
        {sr, rises, falls, sclk_q, cs_q, unlocked, pend, busy, op, adr} = '0;
        {o_drive, o_do} = 2'h0;
    end

    // Frame decode, array update and ready status
    always @(posedge i_clk) begin
        sclk_q <= i_sclk;
        cs_q <= i_cs;
        if (busy != 6'h00)
            busy <= busy - 6'h01;
        if (i_cs && i_sclk && !sclk_q) begin
            sr <= {sr[16:0], i_di};
            rises <= rises + 5'h01;
            if (rises == 5'h09) begin
                op <= sr[7:6];
                adr <= {sr[5:0], i_di};
            end
        end
        if (i_cs && !i_sclk && sclk_q) begin
            falls <= falls + 5'h01;
            // Read data changes after a fall so it is steady at the next one
            o_drive <= (op == 2'h2) && (falls >= 5'h09) && (falls <= 5'h10);
            o_do <= mem[adr][5'h10 - falls];
        end
        if (i_cs && pend && rises == 5'h00 && busy == 6'h00) begin
            o_drive <= 1'b1;
            o_do <= 1'b1;
        end
        if (!i_cs && cs_q) begin
            o_drive <= 1'b0;
            rises <= 5'h00;
            falls <= 5'h00;
            pend <= 1'b0;
            // A locked part ignores program frames and never shows ready
            if (rises != 5'h00 && op != 2'h2) begin
                case ({op, adr[6:5]})
                    4'h3: unlocked <= 1'b1;
                    4'h0: unlocked <= 1'b0;
                    default: begin
                        // Erase, write, clear-all and fill-all need the unlock first
                        if (unlocked) begin
                            pend <= 1'b1;
                            busy <= 6'h1e;
                            for (int j = 0; j < 128; j++) begin
                                if (op == 2'h0 && adr[6:5] == 2'h2)
                                    mem[j] <= 8'hff;
                                else if (op == 2'h0 || j == adr)
                                    mem[j] <= (op == 2'h3) ? 8'hff : sr[7:0];
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [sim/tb_sec_ctrl.sv]
// Self-checking bench for the serial EEPROM host controller
`timescale 1ns/100ps
`default_nettype none
`include "sec_defs.svh"
module tb_sec_ctrl;
    typedef struct packed {
        logic [2:0] code;
        logic [6:0] addr;
        logic [7:0] data;
        logic [7:0] exp_rd;
        logic [6:0] clks;
        logic to;
        logic load;
    } sec_row_s;
    localparam int NROWS = 16;
    localparam logic [47:0] STA = 48'h665544332211;

    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_cs;
    logic o_sclk;
    logic o_sd;
    logic o_sd_oe_n;
    logic [47:0] o_station_addr;
    logic sd_wire;
    logic m_drive;
    logic m_do;
    logic sclk_q = 1'b0;
    logic [9:0] fbits = 10'h0;
    int rises = 0;
    int rise_base = 0;
    int err_count = 0;
    int compares = 0;

    // Operations in order: code, target, data, read byte, clocks, timeout, load flag
    sec_row_s rows [NROWS] = '{
        '{3'h0, 7'h01, 8'h00, 8'h11, 7'h12, 1'b0, 1'b1},
        '{3'h3, 7'h14, 8'h5a, 8'h00, 7'h12, 1'b1, 1'b1},
        '{3'h2, 7'h00, 8'h00, 8'h00, 7'h0a, 1'b0, 1'b1},
        '{3'h3, 7'h14, 8'h5a, 8'h00, 7'h12, 1'b0, 1'b1},
        '{3'h0, 7'h14, 8'h00, 8'h5a, 7'h12, 1'b0, 1'b1},
        '{3'h5, 7'h14, 8'h00, 8'h00, 7'h0a, 1'b0, 1'b1},
        '{3'h0, 7'h14, 8'h00, 8'hff, 7'h12, 1'b0, 1'b1},
        '{3'h7, 7'h00, 8'h00, 8'h00, 7'h7e, 1'b0, 1'b1},
        '{3'h4, 7'h00, 8'h3c, 8'h00, 7'h12, 1'b0, 1'b1},
        '{3'h0, 7'h7f, 8'h00, 8'h3c, 7'h12, 1'b0, 1'b1},
        '{3'h6, 7'h00, 8'h00, 8'h00, 7'h0a, 1'b0, 1'b1},
        '{3'h0, 7'h00, 8'h00, 8'hff, 7'h12, 1'b0, 1'b1},
        '{3'h7, 7'h00, 8'h00, 8'h00, 7'h12, 1'b0, 1'b0},
        '{3'h1, 7'h00, 8'h00, 8'h00, 7'h0a, 1'b0, 1'b0},
        '{3'h5, 7'h05, 8'h00, 8'h00, 7'h0a, 1'b1, 1'b0},
        '{3'h0, 7'h05, 8'h00, 8'hff, 7'h12, 1'b0, 1'b0}};

    sec_ctrl #(.TIMEOUT_CYC(200), .SCLK_HALF(4)) uut (.i_clk(i_clk), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_cs(o_cs), .o_sclk(o_sclk), .o_sd(o_sd), .o_sd_oe_n(o_sd_oe_n), .i_sd(sd_wire),
        .o_station_addr(o_station_addr));
    sec_eeprom_model eep (.i_clk(i_clk), .i_cs(o_cs), .i_sclk(o_sclk), .i_di(sd_wire),
        .o_drive(m_drive), .o_do(m_do));

    // Shared data line; a pull-down holds it low when nobody drives
    assign sd_wire = !o_sd_oe_n ? o_sd : (m_drive ? m_do : 1'b0);

    always #20 i_clk = ~i_clk;

    // Count serial clocks and keep the first ten bits of each operation
    always @(posedge i_clk) begin
        sclk_q <= o_sclk;
        if (o_sclk && !sclk_q) begin
            rises <= rises + 1;
            if (rises - rise_base < 10)
                fbits <= {fbits[8:0], o_sd};
        end
    end

    // Expected start, opcode and address bits
    function automatic logic [9:0] frame_of(logic [2:0] c, logic [6:0] a);
        case (c)
            3'h0: return 10'h300 | {3'h0, a};
            3'h3: return 10'h280 | {3'h0, a};
            3'h5: return 10'h380 | {3'h0, a};
            3'h2: return 10'h260;
            3'h1: return 10'h200;
            3'h6: return 10'h240;
            3'h4: return 10'h220;
            default: return 10'h300;
        endcase
    endfunction

    task automatic give_verdict();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Poll the pending bit under a bounded count
    task automatic wait_idle();
        logic [31:0] d;
        int n;
        n = 0;
        d = 32'h80000000;
        while (d[`SEC_CMD_PEND] !== 1'b0) begin
            rd(`SEC_OFF_CMD, d);
            n++;
            if (n > 3000) begin
                err_count++;
                give_verdict();
            end
        end
    endtask

    initial begin
        logic [31:0] d;
        repeat (16) @(posedge i_clk);
        #1;
        chk("reset_pins", {o_cs, o_sclk, o_sd_oe_n, o_rdata}, {3'h1, 32'h0});
        chk("reset_station", o_station_addr, 48'h0);
        @(posedge i_clk);
        i_reset <= 1'b0;
        rd(`SEC_OFF_CMD, d);
        chk("pend_during_load", d[`SEC_CMD_PEND], 1'b1);
        wr(`SEC_OFF_DATA, 32'h77);
        rd(`SEC_OFF_PINCFG, d);
        chk("pincfg_reset", d, {29'h0, `SEC_PINCFG_RST});
        wait_idle();
        rd(`SEC_OFF_CMD, d);
        chk("load_done", d[`SEC_CMD_LOAD], 1'b1);
        chk("station_loaded", o_station_addr, STA);
        rd(`SEC_OFF_DATA, d);
        chk("data_write_in_load", d[7:0] == 8'h77, 1'b0);
        for (int i = 0; i < NROWS; i++) begin
            if (rows[i].code == 3'h7)
                wr(`SEC_OFF_STA_LO, 32'h0);
            wr(`SEC_OFF_DATA, {24'h0, rows[i].data});
            rise_base = rises;
            wr(`SEC_OFF_CMD, {1'b1, rows[i].code, 21'h0, rows[i].addr});
            wr(`SEC_OFF_DATA, {24'h0, ~rows[i].data});
            wait_idle();
            chk("clocks", rises - rise_base, rows[i].clks);
            chk("frame", fbits, frame_of(rows[i].code, rows[i].addr));
            rd(`SEC_OFF_CMD, d);
            chk("timeout", d[`SEC_CMD_TO], rows[i].to);
            chk("load", d[`SEC_CMD_LOAD], rows[i].load);
            rd(`SEC_OFF_DATA, d);
            if (rows[i].code == 3'h0)
                chk("read_data", d[7:0], rows[i].exp_rd);
            else if (rows[i].code != 3'h7)
                chk("data_kept", d[7:0], rows[i].data);
            if (rows[i].code == 3'h7 && rows[i].load)
                chk("station_reload", o_station_addr, STA);
        end
        // Second command while the first runs is dropped
        rise_base = rises;
        wr(`SEC_OFF_CMD, {4'h9, 28'h0});
        wr(`SEC_OFF_CMD, {4'h8, 21'h0, 7'h05});
        wait_idle();
        chk("busy_cmd_clocks", rises - rise_base, 10);
        chk("busy_cmd_frame", fbits, 10'h200);
        // Disabled interface hands the clock and data pins to general outputs, chip select low
        wr(`SEC_OFF_PINCFG, 32'h6);
        repeat (3) @(posedge i_clk);
        #1;
        chk("pins_released", {o_cs, o_sclk, o_sd_oe_n, o_sd}, 4'h5);
        wr(`SEC_OFF_PINCFG, 32'h1);
        // Mid-run reset: the load restarts and fails on the blank first byte
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        chk("midrun_reset_pins", {o_cs, o_sclk, o_sd_oe_n, o_rdata}, {3'h1, 32'h0});
        chk("midrun_reset_station", o_station_addr, 48'h0);
        @(posedge i_clk);
        i_reset <= 1'b0;
        rd(`SEC_OFF_CMD, d);
        chk("midrun_pend_during_load", d[`SEC_CMD_PEND], 1'b1);
        wait_idle();
        rd(`SEC_OFF_CMD, d);
        chk("midrun_load_failed", d[`SEC_CMD_LOAD], 1'b0);
        chk("midrun_station", o_station_addr, 48'h0);
        rd(8'h20, d);
        chk("unmapped_read", d, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
